// file: pmu_dac_pkg.sv
// Shared constants and carrier types for the PMU DAC level and calibration block.
// Assumes a single core clock and an AXI4-Lite register master.
package pmu_dac_pkg;
  localparam int NUM_CH = 4;
  localparam int NUM_DAC = 5;
  localparam int NUM_SLOT = 6;
  localparam int CODE_W = 16;
  localparam int CFG_W = 22;
  localparam int ADDR_W = 8;
  localparam int IRQ_W = 4;

  localparam logic [ADDR_W-1:0] SYS_CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] IRQ_STATUS_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] IRQ_CLEAR_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] IRQ_ENABLE_OFS = 8'h0c;
  localparam logic [ADDR_W-1:0] OFFSET_DAC_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] ALARM_STATUS_OFS = 8'h14;
  localparam logic [ADDR_W-1:0] COMP_STATUS_OFS = 8'h18;
  localparam logic [ADDR_W-1:0] CH_CFG_OFS = 8'h20;
  localparam logic [ADDR_W-1:0] CODE_SELECT_OFS = 8'h40;
  localparam logic [ADDR_W-1:0] CODE_DATA_OFS = 8'h44;

  localparam logic [CODE_W-1:0] GAIN_RESET = 16'hffff;
  localparam logic [CODE_W-1:0] OFFSET_COEF_RESET = 16'h8000;
  localparam logic [CODE_W-1:0] MIDSCALE = 16'h8000;
  localparam logic [CODE_W-1:0] OFFSET_DAC_RESET = 16'ha492;
  // Index order: force level, clamp low, clamp high, comparator low, comparator high
  localparam logic [NUM_DAC-1:0][CODE_W-1:0] DAC_RESET = {16'hffff, 16'h0000, 16'hffff, 16'h0000, 16'h8000};
  localparam int FORCE_LEVEL_DAC = 0;
  localparam int CLAMP_LOW_DAC = 1;
  localparam int CLAMP_HIGH_DAC = 2;
  localparam int COMPARATOR_LOW_DAC = 3;

  localparam logic [31:0] ALARM_STATUS_RESET = 32'h00fffff0;
  localparam logic [31:0] COMP_STATUS_RESET = 32'h00400000;
  localparam logic [CFG_W-1:0] SYS_CTRL_RESET = 22'h000020;
  localparam logic [CFG_W-1:0] CH_CFG_RESET = 22'h01e060;

  localparam int CFG_CHANNEL_ON = 21;
  localparam int CFG_FORCE_MODE_SEL_HI = 20;
  localparam int CFG_FORCE_MODE_SEL_LO = 19;
  localparam int CFG_CURRENT_RANGE_LSB = 15;
  localparam int CFG_COMPARE_CURRENT = 7;
  localparam int CFG_THERMAL_ALARM_STICKY = 6;
  localparam int CFG_THERMAL_ALARM_LIVE = 5;

  localparam int SEL_KIND_LSB = 0;
  localparam int SEL_DAC_LSB = 2;
  localparam int SEL_SLOT_LSB = 5;
  localparam int SEL_CH_LSB = 8;
  localparam logic [1:0] KIND_INPUT = 2'h0;
  localparam logic [1:0] KIND_GAIN = 2'h1;
  localparam logic [1:0] KIND_OFFSET = 2'h2;
  localparam logic [1:0] KIND_CORRECTED = 2'h3;

  localparam int IRQ_CODE_STORED = 0;
  localparam int IRQ_CFG_LOAD = 1;
  localparam int IRQ_DIRECT_LOAD = 2;
  localparam int IRQ_SATURATED = 3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic awvalid;
    logic [31:0] awaddr;
    logic [2:0] awprot;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [31:0] araddr;
    logic [2:0] arprot;
    logic rready;
  } axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_t;

  typedef logic [NUM_CH-1:0][NUM_DAC-1:0][CODE_W-1:0] level_array_t;
endpackage

// file: pmu_dac_level_calibration_load.sv
// Four-channel PMU DAC code store, calibration engine and level load logic.
// Assumes an AXI4-Lite master on core_clk and an asynchronous thermal alarm pin.
//
// Overview of operation
// - Reset loads every gain coefficient with full scale, every offset with midscale.
// - Alarm status resets to 0xFFFFF0, comparator status to 0x400000.
// - Input codes reset to offset A492, force 8000, clamps 0/FFFF, comparators 0/FFFF.
// - System control resets to zero except thermal shutdown enable bit 5.
// - Channel config resets with bits 16..13, 6 and 5 set.
// - Reset puts every channel and DAC into a known default state.
// - Each input code write is calibrated and the corrected code stored.
// - Config write sets switches and loads stored corrected codes into that channel's DACs.
// - Selected mode and range pick the slot; only that slot's writes reach the DAC.
// - Writes to an unselected slot are corrected and stored but not loaded.
// - Separate input and corrected codes per voltage range and current range.
// - High-impedance modes via bits 20 and 19 open the amplifier output switch.
// - In high-impedance modes force and clamp writes are corrected before they load into the DAC.
// - In voltage forcing, current clamp writes are corrected and loaded.
`timescale 1ns/1ps
`default_nettype none
module pmu_dac_level_calibration_load
  import pmu_dac_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire axil_req_t s_req,
  output axil_rsp_t s_rsp,
  input wire logic thermal_alarm_in,
  output level_array_t dac_level,
  output logic [CODE_W-1:0] offset_dac_level,
  output logic [NUM_CH-1:0] amp_output_switch,
  output logic [NUM_CH-1:0][CFG_W-1:0] channel_config,
  output logic [CFG_W-1:0] system_control,
  output logic irq
);
  typedef struct packed {
    logic aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    axil_rsp_t rsp;
    logic [CFG_W-1:0] sys_ctrl;
    logic [NUM_CH-1:0][CFG_W-1:0] ch_cfg;
    logic [CODE_W-1:0] offset_code;
    logic [9:0] code_sel;
    logic [NUM_CH-1:0][NUM_DAC-1:0][CODE_W-1:0] gain;
    logic [NUM_CH-1:0][NUM_DAC-1:0][CODE_W-1:0] offset;
    logic [NUM_CH-1:0][NUM_DAC-1:0][NUM_SLOT-1:0][CODE_W-1:0] in_code;
    logic [NUM_CH-1:0][NUM_DAC-1:0][NUM_SLOT-1:0][CODE_W-1:0] corr_code;
    level_array_t level;
    logic [NUM_CH-1:0] amp_closed;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_enable;
    logic irq;
    logic hot_meta;
    logic hot;
  } state_t;

  state_t q;
  state_t next_q;

  // Voltage slot is 0; current ranges take slots 1 and up
  function automatic logic [2:0] select_slot(input logic [CFG_W-1:0] cfg, input int dac);
    logic [2:0] irange;
    logic current_side;
    irange = cfg[CFG_CURRENT_RANGE_LSB +: 3];
    if (irange > 3'(NUM_SLOT - 2)) begin
      irange = 3'(NUM_SLOT - 2);
    end
    if (dac == FORCE_LEVEL_DAC) begin
      current_side = cfg[CFG_FORCE_MODE_SEL_LO];
    end else if (dac < COMPARATOR_LOW_DAC) begin
      // Clamps limit the opposite quantity to the one forced
      current_side = ~cfg[CFG_FORCE_MODE_SEL_LO];
    end else begin
      current_side = cfg[CFG_COMPARE_CURRENT];
    end
    return current_side ? irange + 3'h1 : 3'h0;
  endfunction

  // Returns {saturated, code}
  function automatic logic [CODE_W:0] calibrate(input logic [CODE_W-1:0] x, input logic [CODE_W-1:0] m,
                                                input logic [CODE_W-1:0] c);
    logic [32:0] prod;
    logic [CODE_W:0] scaled;
    logic signed [18:0] sum;
    // Full-scale gain is unity and a midscale offset adds nothing
    prod = 33'(x) * 33'({1'b0, m} + 17'h00001);
    scaled = prod[32:16];
    sum = $signed({2'b00, scaled}) + $signed({3'b000, c}) - $signed({3'b000, MIDSCALE});
    if (sum < 0) begin
      return {1'b1, 16'h0000};
    end else if (sum > $signed(19'h0ffff)) begin
      return {1'b1, 16'hffff};
    end
    return {1'b0, sum[CODE_W-1:0]};
  endfunction

  function automatic logic is_cfg(input logic [ADDR_W-1:0] a);
    return a >= CH_CFG_OFS && a < CH_CFG_OFS + ADDR_W'(4 * NUM_CH);
  endfunction

  function automatic logic sel_ok(input logic [9:0] sel);
    return sel[SEL_DAC_LSB +: 3] < 3'(NUM_DAC) && sel[SEL_SLOT_LSB +: 3] < 3'(NUM_SLOT);
  endfunction

  // Registers take whole aligned words; the low address bits are ignored
  function automatic logic [ADDR_W-1:0] word_addr(input logic [31:0] a);
    return {a[ADDR_W-1:2], 2'b00};
  endfunction

  function automatic logic [1:0] cfg_channel(input logic [ADDR_W-1:0] a);
    return a[3:2];
  endfunction

  // Byte lanes without a strobe keep the register's current value
  function automatic logic [31:0] merge_bytes(input logic [31:0] cur, input logic [31:0] data,
                                              input logic [3:0] strb);
    logic [31:0] m;
    m = cur;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        m[8*b +: 8] = data[8*b +: 8];
      end
    end
    return m;
  endfunction

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    case (a)
      SYS_CTRL_OFS, IRQ_STATUS_OFS, IRQ_CLEAR_OFS, IRQ_ENABLE_OFS, OFFSET_DAC_OFS,
      ALARM_STATUS_OFS, COMP_STATUS_OFS, CODE_SELECT_OFS, CODE_DATA_OFS: begin
        return 1'b1;
      end
      default: begin
        return is_cfg(a);
      end
    endcase
  endfunction

  function automatic logic [31:0] reg_value(input state_t s, input logic [ADDR_W-1:0] a);
    logic [1:0] ch;
    logic [2:0] d;
    logic [2:0] sl;
    ch = s.code_sel[SEL_CH_LSB +: 2];
    d = s.code_sel[SEL_DAC_LSB +: 3];
    sl = s.code_sel[SEL_SLOT_LSB +: 3];
    case (a)
      SYS_CTRL_OFS: return 32'(s.sys_ctrl);
      IRQ_STATUS_OFS: return 32'(s.irq_status);
      IRQ_ENABLE_OFS: return 32'(s.irq_enable);
      OFFSET_DAC_OFS: return 32'(s.offset_code);
      ALARM_STATUS_OFS: return ALARM_STATUS_RESET;
      COMP_STATUS_OFS: return COMP_STATUS_RESET;
      CODE_SELECT_OFS: return 32'(s.code_sel);
      CODE_DATA_OFS: begin
        if (!sel_ok(s.code_sel)) begin
          return 32'h00000000;
        end
        case (s.code_sel[SEL_KIND_LSB +: 2])
          KIND_INPUT: return 32'(s.in_code[ch][d][sl]);
          KIND_GAIN: return 32'(s.gain[ch][d]);
          KIND_OFFSET: return 32'(s.offset[ch][d]);
          default: return 32'(s.corr_code[ch][d][sl]);
        endcase
      end
      default: begin
        if (is_cfg(a)) begin
          return 32'(s.ch_cfg[cfg_channel(a)]);
        end
        return 32'h00000000;
      end
    endcase
  endfunction

  always_comb begin
    logic [31:0] wd;
    logic [IRQ_W-1:0] clr;
    logic [IRQ_W-1:0] ev;
    logic [1:0] ch;
    logic [2:0] d;
    logic [2:0] sl;
    logic [CODE_W:0] cal;
    logic [1:0] cc;
    next_q = q;
    wd = merge_bytes(reg_value(q, q.aw_addr), q.w_data, q.w_strb);
    clr = '0;
    ev = '0;
    ch = q.code_sel[SEL_CH_LSB +: 2];
    d = q.code_sel[SEL_DAC_LSB +: 3];
    sl = q.code_sel[SEL_SLOT_LSB +: 3];
    cal = '0;
    cc = cfg_channel(q.aw_addr);
    // Only the second flop is read; the first may still be settling
    next_q.hot_meta = thermal_alarm_in;
    next_q.hot = q.hot_meta;

    if (s_req.awvalid && q.rsp.awready) begin
      next_q.aw_held = 1'b1;
      next_q.aw_addr = word_addr(s_req.awaddr);
      next_q.rsp.awready = 1'b0;
    end
    if (s_req.wvalid && q.rsp.wready) begin
      next_q.w_held = 1'b1;
      next_q.w_data = s_req.wdata;
      next_q.w_strb = s_req.wstrb;
      next_q.rsp.wready = 1'b0;
    end
    // One write in flight: address and data reopen only once the response is taken
    if (q.rsp.bvalid && s_req.bready) begin
      next_q.rsp.bvalid = 1'b0;
      next_q.rsp.awready = 1'b1;
      next_q.rsp.wready = 1'b1;
    end

    if (q.aw_held && q.w_held && !q.rsp.bvalid) begin
      next_q.aw_held = 1'b0;
      next_q.w_held = 1'b0;
      next_q.rsp.bvalid = 1'b1;
      next_q.rsp.bresp = is_mapped(q.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      case (q.aw_addr)
        SYS_CTRL_OFS: next_q.sys_ctrl = wd[CFG_W-1:0];
        IRQ_CLEAR_OFS: clr = q.w_data[IRQ_W-1:0];
        IRQ_ENABLE_OFS: next_q.irq_enable = wd[IRQ_W-1:0];
        OFFSET_DAC_OFS: next_q.offset_code = wd[CODE_W-1:0];
        CODE_SELECT_OFS: next_q.code_sel = wd[9:0];
        CODE_DATA_OFS: begin
          if (!sel_ok(q.code_sel)) begin
            next_q.rsp.bresp = RESP_SLVERR;
          end else begin
            case (q.code_sel[SEL_KIND_LSB +: 2])
              KIND_INPUT: begin
                next_q.in_code[ch][d][sl] = wd[CODE_W-1:0];
                cal = calibrate(wd[CODE_W-1:0], q.gain[ch][d], q.offset[ch][d]);
                next_q.corr_code[ch][d][sl] = cal[CODE_W-1:0];
                ev[IRQ_CODE_STORED] = 1'b1;
                ev[IRQ_SATURATED] = cal[CODE_W];
                // Same slot as the live mode, including high-Z and clamp cases
                if (sl == select_slot(q.ch_cfg[ch], int'(d))) begin
                  next_q.level[ch][d] = cal[CODE_W-1:0];
                  ev[IRQ_DIRECT_LOAD] = 1'b1;
                end
              end
              KIND_GAIN: next_q.gain[ch][d] = wd[CODE_W-1:0];
              KIND_OFFSET: next_q.offset[ch][d] = wd[CODE_W-1:0];
              default: next_q.rsp.bresp = RESP_SLVERR;
            endcase
          end
        end
        default: begin
          if (is_cfg(q.aw_addr)) begin
            next_q.ch_cfg[cc] = wd[CFG_W-1:0];
            next_q.ch_cfg[cc][CFG_THERMAL_ALARM_LIVE] = q.hot;
            // Writing one to the sticky bit clears it
            next_q.ch_cfg[cc][CFG_THERMAL_ALARM_STICKY] =
              q.ch_cfg[cc][CFG_THERMAL_ALARM_STICKY] & ~q.w_data[CFG_THERMAL_ALARM_STICKY];
            for (int k = 0; k < NUM_DAC; k++) begin
              next_q.level[cc][k] = q.corr_code[cc][k][select_slot(wd[CFG_W-1:0], k)];
            end
            ev[IRQ_CFG_LOAD] = 1'b1;
          end
        end
      endcase
    end

    if (s_req.arvalid && q.rsp.arready) begin
      next_q.rsp.arready = 1'b0;
      next_q.rsp.rvalid = 1'b1;
      next_q.rsp.rdata = reg_value(q, word_addr(s_req.araddr));
      next_q.rsp.rresp = is_mapped(word_addr(s_req.araddr)) ? RESP_OKAY : RESP_SLVERR;
    end
    if (q.rsp.rvalid && s_req.rready) begin
      next_q.rsp.rvalid = 1'b0;
      next_q.rsp.arready = 1'b1;
    end

    for (int c = 0; c < NUM_CH; c++) begin
      next_q.ch_cfg[c][CFG_THERMAL_ALARM_LIVE] = q.hot;
      // Alarm still present wins over a clear in the same cycle
      if (q.hot) begin
        next_q.ch_cfg[c][CFG_THERMAL_ALARM_STICKY] = 1'b1;
      end
      next_q.amp_closed[c] = next_q.ch_cfg[c][CFG_CHANNEL_ON] & ~next_q.ch_cfg[c][CFG_FORCE_MODE_SEL_HI];
    end

    next_q.irq_status = (q.irq_status & ~clr) | ev;
    next_q.irq = |(next_q.irq_status & next_q.irq_enable);
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
      q.rsp.awready <= 1'b1;
      q.rsp.wready <= 1'b1;
      q.rsp.arready <= 1'b1;
      // Alarm flops start asserted to match the alarm bits' reset value
      q.hot_meta <= 1'b1;
      q.hot <= 1'b1;
      q.sys_ctrl <= SYS_CTRL_RESET;
      q.ch_cfg <= {NUM_CH{CH_CFG_RESET}};
      q.offset_code <= OFFSET_DAC_RESET;
      q.gain <= {NUM_CH * NUM_DAC{GAIN_RESET}};
      q.offset <= {NUM_CH * NUM_DAC{OFFSET_COEF_RESET}};
      for (int c = 0; c < NUM_CH; c++) begin
        for (int k = 0; k < NUM_DAC; k++) begin
          q.in_code[c][k] <= {NUM_SLOT{DAC_RESET[k]}};
          q.corr_code[c][k] <= {NUM_SLOT{DAC_RESET[k]}};
          q.level[c][k] <= DAC_RESET[k];
        end
      end
    end else begin
      q <= next_q;
    end
  end

  assign s_rsp = q.rsp;
  assign dac_level = q.level;
  assign offset_dac_level = q.offset_code;
  assign amp_output_switch = q.amp_closed;
  assign channel_config = q.ch_cfg;
  assign system_control = q.sys_ctrl;
  assign irq = q.irq;
endmodule
`default_nettype wire

// file: pmu_dac_asserts.sv
// Port-level checks for the PMU DAC level block.
// Assumes one core_clk domain and rstn asynchronous, active low.
`timescale 1ns/1ps
`default_nettype none
module pmu_dac_checker
  import pmu_dac_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire axil_req_t s_req,
  input wire axil_rsp_t s_rsp,
  input wire level_array_t dac_level,
  input wire logic [CODE_W-1:0] offset_dac_level,
  input wire logic [NUM_CH-1:0] amp_output_switch,
  input wire logic [NUM_CH-1:0][CFG_W-1:0] channel_config,
  input wire logic [CFG_W-1:0] system_control,
  input wire logic irq
);
  logic [NUM_CH-1:0] exp_sw;
  logic [NUM_CH-1:0] live_not_sticky;
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      exp_sw[i] = channel_config[i][CFG_CHANNEL_ON] & ~channel_config[i][CFG_FORCE_MODE_SEL_HI];
      live_not_sticky[i] = channel_config[i][CFG_THERMAL_ALARM_LIVE] & ~channel_config[i][CFG_THERMAL_ALARM_STICKY];
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  chk_reset_vals: assert property ($rose(rstn) |-> dac_level == {NUM_CH{DAC_RESET}}
    && offset_dac_level == OFFSET_DAC_RESET && system_control == SYS_CTRL_RESET
    && channel_config == {NUM_CH{CH_CFG_RESET}} && amp_output_switch == '0) else $error("bad reset values");
  chk_switch_decode: assert property (amp_output_switch == exp_sw) else $error("switch vs mode");
  chk_level_cause: assert property ($changed(dac_level) |-> $rose(s_rsp.bvalid))
    else $error("level moved without write");
  chk_irq_cause: assert property ($rose(irq) |-> $rose(s_rsp.bvalid)) else $error("irq rose without write");
  chk_b_blocks_aw: assert property (s_rsp.bvalid |-> !s_rsp.awready && !s_rsp.wready)
    else $error("write taken while answering");
  chk_b_one_beat: assert property (s_rsp.bvalid && s_req.bready |=> !s_rsp.bvalid) else $error("bvalid stuck");
  chk_r_one_beat: assert property (s_rsp.rvalid && s_req.rready |=> !s_rsp.rvalid && s_rsp.arready)
    else $error("read not closed");
  chk_refused_zero: assert property (s_rsp.rvalid && s_rsp.rresp == RESP_SLVERR |-> s_rsp.rdata == '0)
    else $error("refused read data");
  chk_alarm_latched: assert property (live_not_sticky == '0) else $error("live alarm not latched");
endmodule
bind pmu_dac_level_calibration_load pmu_dac_checker u_pmu_dac_checker (.core_clk(core_clk), .rstn(rstn),
  .s_req(s_req), .s_rsp(s_rsp), .dac_level(dac_level), .offset_dac_level(offset_dac_level),
  .amp_output_switch(amp_output_switch), .channel_config(channel_config), .system_control(system_control),
  .irq(irq));
`default_nettype wire

// file: host_model.sv
// Host controller model: AXI4-Lite master programming the block.
// Assumes it is the only master on the bus.
`timescale 1ns/1ps
`default_nettype none
module host_model
  import pmu_dac_pkg::*;
(
  input wire logic core_clk,
  input wire axil_rsp_t rsp,
  output var axil_req_t req
);
  initial req = '0;
  // Leading edge keeps a new request off the edge that ended the last one
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] resp);
    @(posedge core_clk);
    req.awaddr <= {24'h0, a};
    req.awvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid);
    resp = rsp.bresp;
    req.bready <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge core_clk);
    req.araddr <= {24'h0, a};
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid);
    d = rsp.rdata;
    resp = rsp.rresp;
    req.rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the PMU DAC level block.
// Assumes host_model as master and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import pmu_dac_pkg::*;
();
  typedef struct packed {
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [31:0] data;
    logic [1:0] resp;
  } row_t;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic alarm_pin = 1'b1;
  axil_req_t s_req;
  axil_rsp_t s_rsp;
  level_array_t dac_level;
  logic [CODE_W-1:0] offset_dac_level;
  logic [NUM_CH-1:0] amp_output_switch;
  logic [NUM_CH-1:0][CFG_W-1:0] channel_config;
  logic [CFG_W-1:0] system_control;
  logic irq;
  logic [31:0] rdat;
  logic [1:0] resp;
  int failures = 0;
  int n_compared = 0;
  row_t rows [14] = '{
    '{1'b0, SYS_CTRL_OFS, 32'h20, RESP_OKAY},
    '{1'b0, ALARM_STATUS_OFS, ALARM_STATUS_RESET, RESP_OKAY},
    '{1'b0, COMP_STATUS_OFS, COMP_STATUS_RESET, RESP_OKAY},
    '{1'b0, 8'h2c, 32'h01e060, RESP_OKAY},
    '{1'b0, OFFSET_DAC_OFS, 32'ha492, RESP_OKAY},
    '{1'b0, 8'h30, 32'h0, RESP_SLVERR},
    '{1'b1, 8'h30, 32'h1, RESP_SLVERR},
    '{1'b1, CODE_SELECT_OFS, 32'h1, RESP_OKAY},
    '{1'b0, CODE_DATA_OFS, 32'hffff, RESP_OKAY},
    '{1'b1, CODE_SELECT_OFS, 32'h30a, RESP_OKAY},
    '{1'b0, CODE_DATA_OFS, 32'h8000, RESP_OKAY},
    '{1'b1, CODE_SELECT_OFS, 32'h3, RESP_OKAY},
    '{1'b1, CODE_DATA_OFS, 32'h5, RESP_SLVERR},
    '{1'b0, IRQ_CLEAR_OFS, 32'h0, RESP_OKAY}};
  always #5 core_clk = ~core_clk;
  host_model u_host_model (.core_clk(core_clk), .rsp(s_rsp), .req(s_req));
  pmu_dac_level_calibration_load u_pmu_dac_level_calibration_load (.core_clk(core_clk), .rstn(rstn),
    .s_req(s_req), .s_rsp(s_rsp), .thermal_alarm_in(alarm_pin), .dac_level(dac_level),
    .offset_dac_level(offset_dac_level), .amp_output_switch(amp_output_switch),
    .channel_config(channel_config), .system_control(system_control), .irq(irq));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic w(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    u_host_model.wr(a, d, resp);
    chk({30'h0, resp}, {30'h0, RESP_OKAY}, "bresp");
  endtask
  task automatic do_reset();
    rstn <= 1'b0;
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    for (int c = 0; c < NUM_CH; c++) begin
      for (int d = 0; d < NUM_DAC; d++) chk(32'(dac_level[c][d]), 32'(DAC_RESET[d]), "dac default");
      chk(32'(channel_config[c]), 32'(CH_CFG_RESET), "cfg default");
    end
    chk(32'(offset_dac_level), 32'(OFFSET_DAC_RESET), "offset default");
    chk(32'(system_control), 32'(SYS_CTRL_RESET), "sysctl default");
    chk(32'({amp_output_switch, irq}), 32'h0, "switch irq default");
    $display("test reset done");
  endtask
  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    $display("mismatch at %0t: watchdog expired", $time);
    report_and_stop();
  end
  initial begin
    do_reset();
    foreach (rows[i]) begin
      if (rows[i].wr) u_host_model.wr(rows[i].addr, rows[i].data, resp);
      else u_host_model.rd(rows[i].addr, rdat, resp);
      if (!rows[i].wr) chk(rdat, rows[i].data, "read value");
      chk({30'h0, resp}, {30'h0, rows[i].resp}, "response");
    end
    $display("test rows done");
    w(SYS_CTRL_OFS, 32'h20);
    w(IRQ_ENABLE_OFS, 32'h8);
    w(CODE_SELECT_OFS, 32'h1);
    w(CODE_DATA_OFS, 32'h7fff);
    w(CODE_SELECT_OFS, 32'h2);
    w(CODE_DATA_OFS, 32'h8010);
    w(CODE_SELECT_OFS, 32'h0);
    w(CODE_DATA_OFS, 32'h1000);
    chk(32'(dac_level[0][0]), 32'h0810, "selected slot");
    w(CODE_SELECT_OFS, 32'h20);
    w(CODE_DATA_OFS, 32'h2000);
    chk(32'(dac_level[0][0]), 32'h0810, "other slot held");
    w(CODE_SELECT_OFS, 32'h23);
    u_host_model.rd(CODE_DATA_OFS, rdat, resp);
    chk(rdat, 32'h1010, "stored corrected");
    w(CH_CFG_OFS, 32'h280000);
    chk(32'(dac_level[0][0]), 32'h1010, "config load");
    chk(32'(amp_output_switch), 32'h1, "switch closed");
    chk(32'(irq), 32'h0, "irq quiet");
    $display("test calibration done");
    w(CODE_SELECT_OFS, 32'h2);
    w(CODE_DATA_OFS, 32'h0);
    w(CODE_SELECT_OFS, 32'h20);
    w(CODE_DATA_OFS, 32'h1000);
    chk(32'(dac_level[0][0]), 32'h0, "low clamp");
    chk(32'(irq), 32'h1, "saturation irq");
    u_host_model.rd(IRQ_STATUS_OFS, rdat, resp);
    chk(rdat, 32'hf, "irq status");
    w(IRQ_ENABLE_OFS, 32'h0);
    chk(32'(irq), 32'h0, "masked");
    w(IRQ_ENABLE_OFS, 32'h8);
    chk(32'(irq), 32'h1, "unmasked");
    w(IRQ_CLEAR_OFS, 32'hf);
    chk(32'(irq), 32'h0, "cleared");
    $display("test saturation done");
    w(CH_CFG_OFS, 32'h300000);
    chk(32'(amp_output_switch), 32'h0, "switch open");
    w(CODE_SELECT_OFS, 32'h1);
    w(CODE_DATA_OFS, 32'hffff);
    w(CODE_SELECT_OFS, 32'h2);
    w(CODE_DATA_OFS, 32'hffff);
    w(CODE_SELECT_OFS, 32'h0);
    w(CODE_DATA_OFS, 32'h9000);
    chk(32'(dac_level[0][0]), 32'hffff, "high clamp direct");
    w(CODE_SELECT_OFS, 32'h24);
    w(CODE_DATA_OFS, 32'h4000);
    chk(32'(dac_level[0][1]), 32'h4000, "clamp direct");
    $display("test high impedance done");
    w(OFFSET_DAC_OFS, 32'h1234);
    chk(32'(offset_dac_level), 32'h1234, "offset dac write");
    alarm_pin <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk(32'(channel_config[2]), 32'h01e040, "live alarm cleared");
    w(CH_CFG_OFS + 8'h04, 32'h3800c0);
    chk(32'(channel_config[1]), 32'h380080, "sticky alarm cleared");
    chk(32'(amp_output_switch), 32'h0, "high-z current open");
    alarm_pin <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk(32'(channel_config[1]), 32'h3800e0, "alarm latched again");
    $display("test thermal alarm done");
    do_reset();
    report_and_stop();
  end
endmodule
`default_nettype wire
